// File: hw/din_cond_pkg.sv
// Purpose: Shared constants for the digital input conditioner
// Assumes: 40 MHz system clock
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
package din_cond_pkg;
  localparam int CLOCK_PERIOD_PS = 25000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES = MS_PS / CLOCK_PERIOD_PS;
  localparam int SCAN_MS = 5;
  localparam int AC_EXTRA_MS = 30;
  localparam int DELAY_W = 21;
  localparam int COUNT_W = 22;
  localparam int MS_CNT_W = 16;
  localparam int SCAN_CNT_W = 3;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_LOGIC = 8'h04;
  localparam logic [7:0] OFS_OUTPUT = 8'h08;
  localparam logic [7:0] OFS_POLARITY = 8'h0C;
  localparam logic [7:0] OFS_AC_MODE = 8'h10;
  localparam logic [7:0] OFS_SAMPLED = 8'h14;
  localparam logic [7:0] OFS_ACT_BASE = 8'h40;
  localparam logic [7:0] OFS_DROP_BASE = 8'h80;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 21'h000000;
endpackage : din_cond_pkg

// File: hw/input_channel_filter.sv
// Purpose: One input channel: polarity, activation and drop-off delays, AC extension
// Assumes: Ticks are one-cycle pulses from the top-level divider
// Notes: Delays count whole millisecond ticks; a zero delay acts on the next clock
`timescale 1ns/1ps
`default_nettype none
module input_channel_filter (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_ms_tick,
  input wire logic i_scan_tick,
  input wire logic i_raw,
  input wire logic i_polarity,
  input wire logic i_ac_en,
  input wire logic [din_cond_pkg::DELAY_W-1:0] i_act_delay,
  input wire logic [din_cond_pkg::DELAY_W-1:0] i_drop_delay,
  output logic o_sampled,
  output logic o_status
);
  localparam int COUNT_W = din_cond_pkg::COUNT_W;

  logic sampled_ff;
  logic nxt_sampled;
  logic status_ff;
  logic nxt_status;
  logic [din_cond_pkg::COUNT_W-1:0] cnt_ff;
  logic [din_cond_pkg::COUNT_W-1:0] nxt_cnt;
  logic [din_cond_pkg::COUNT_W-1:0] target;

  assign o_sampled = sampled_ff;
  assign o_status = status_ff;

  always_comb begin
    nxt_sampled = sampled_ff;
    nxt_status = status_ff;
    nxt_cnt = cnt_ff;
    if (sampled_ff) begin
      target = {1'b0, i_act_delay};
    end else begin
      target = {1'b0, i_drop_delay} + (i_ac_en ? COUNT_W'(din_cond_pkg::AC_EXTRA_MS) : '0);
    end
    if (i_scan_tick) begin
      nxt_sampled = i_raw ^ i_polarity;
    end
    if (sampled_ff == status_ff) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= target) begin
      nxt_status = sampled_ff;
      nxt_cnt = '0;
    end else if (i_ms_tick) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sampled_ff <= 1'b0;
      status_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      sampled_ff <= nxt_sampled;
      status_ff <= nxt_status;
      cnt_ff <= nxt_cnt;
    end
  end

  a_polarity_sample: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_scan_tick |=> sampled_ff == ($past(i_raw) ^ $past(i_polarity)))
    else $error("sampled level ignores polarity");
  a_rise_waits: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(status_ff) |-> $past(sampled_ff) && ($past(cnt_ff) >= {1'b0, $past(i_act_delay)}))
    else $error("status rose before activation delay");
  a_fall_waits: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $fell(status_ff) && !$past(i_ac_en) |-> $past(cnt_ff) >= {1'b0, $past(i_drop_delay)})
    else $error("status fell before drop-off delay");
  a_ac_extends: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $fell(status_ff) && $past(i_ac_en) |-> $past(cnt_ff) >= ({1'b0, $past(i_drop_delay)} + 22'h00001E))
    else $error("AC extension missing on drop-off");
  a_cancel_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (sampled_ff == status_ff) |=> $stable(status_ff) && (cnt_ff == '0))
    else $error("status moved without a pending change");
endmodule : input_channel_filter
`default_nettype wire

// File: hw/digital_input_conditioner.sv
// Purpose: Scans and conditions digital inputs, exposes them to logic and outputs
// Assumes: Inputs synchronous to i_clock; Avalon-MM master holds requests until waitrequest low
// Notes: Each access takes two cycles: waitrequest drops in the second
//
// Behaviour
// - Each input has a polarity bit; clear reports the energized level as 1, set reports it as 0.
// - The reported status rises only after the activation delay in milliseconds has passed.
// - The reported status falls only after the drop-off delay in milliseconds has passed.
// - With AC mode enabled the drop-off delay is lengthened by 30 ms.
// - Every input is sampled once per 5 ms scan, so its state updates 0 to 5 ms after a change.
// - Internal logic sees the conditioned state at the next scan, a further 0 to 5 ms later.
// - A digital output fed by an input changes one more 5 ms round after the logic state.
`timescale 1ns/1ps
`default_nettype none
module digital_input_conditioner #(
  parameter int N_INPUTS = 8,
  parameter int MS_CYCLES = din_cond_pkg::MS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [N_INPUTS-1:0] i_digital_input_n,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic [N_INPUTS-1:0] o_status,
  output logic [N_INPUTS-1:0] o_logic_state,
  output logic [N_INPUTS-1:0] o_digital_output_n
);
  logic [din_cond_pkg::MS_CNT_W-1:0] ms_cnt_ff;
  logic [din_cond_pkg::MS_CNT_W-1:0] nxt_ms_cnt;
  logic [din_cond_pkg::SCAN_CNT_W-1:0] scan_cnt_ff;
  logic [din_cond_pkg::SCAN_CNT_W-1:0] nxt_scan_cnt;
  logic ms_tick_ff;
  logic nxt_ms_tick;
  logic scan_tick_ff;
  logic nxt_scan_tick;
  logic [N_INPUTS-1:0] logic_ff;
  logic [N_INPUTS-1:0] nxt_logic;
  logic [N_INPUTS-1:0] out_ff;
  logic [N_INPUTS-1:0] nxt_out;
  logic [N_INPUTS-1:0] sampled;

  localparam logic [din_cond_pkg::MS_CNT_W-1:0] MS_LAST = din_cond_pkg::MS_CNT_W'(MS_CYCLES - 1);
  localparam logic [din_cond_pkg::SCAN_CNT_W-1:0] SCAN_LAST =
    din_cond_pkg::SCAN_CNT_W'(din_cond_pkg::SCAN_MS - 1);

  // Millisecond and scan dividers
  always_comb begin
    nxt_ms_cnt = ms_cnt_ff + 1'b1;
    nxt_ms_tick = 1'b0;
    nxt_scan_cnt = scan_cnt_ff;
    nxt_scan_tick = 1'b0;
    if (ms_cnt_ff == MS_LAST) begin
      nxt_ms_cnt = '0;
      nxt_ms_tick = 1'b1;
      if (scan_cnt_ff == SCAN_LAST) begin
        nxt_scan_cnt = '0;
        nxt_scan_tick = 1'b1;
      end else begin
        nxt_scan_cnt = scan_cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ms_cnt_ff <= '0;
      scan_cnt_ff <= '0;
      ms_tick_ff <= 1'b0;
      scan_tick_ff <= 1'b0;
    end else begin
      ms_cnt_ff <= nxt_ms_cnt;
      scan_cnt_ff <= nxt_scan_cnt;
      ms_tick_ff <= nxt_ms_tick;
      scan_tick_ff <= nxt_scan_tick;
    end
  end

  // Register file
  logic [N_INPUTS-1:0] pol_ff;
  logic [N_INPUTS-1:0] nxt_pol;
  logic [N_INPUTS-1:0] ac_ff;
  logic [N_INPUTS-1:0] nxt_ac;
  logic [din_cond_pkg::DELAY_W-1:0] act_ff [N_INPUTS];
  logic [din_cond_pkg::DELAY_W-1:0] nxt_act [N_INPUTS];
  logic [din_cond_pkg::DELAY_W-1:0] drop_ff [N_INPUTS];
  logic [din_cond_pkg::DELAY_W-1:0] nxt_drop [N_INPUTS];
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wait_ff;
  logic nxt_wait;
  logic req;
  logic wr_take;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  assign req = i_read | i_write;
  assign wr_take = i_write & ~wait_ff;

  always_comb begin
    nxt_pol = pol_ff;
    nxt_ac = ac_ff;
    nxt_rdata = rdata_ff;
    // First cycle of a request raises the answer; the next edge completes it
    nxt_wait = ~(req & wait_ff);
    for (int k = 0; k < N_INPUTS; k++) begin
      nxt_act[k] = act_ff[k];
      nxt_drop[k] = drop_ff[k];
    end
    if (wr_take) begin
      if (i_address == din_cond_pkg::OFS_POLARITY) begin
        nxt_pol = N_INPUTS'(merge_bytes(32'(pol_ff), i_writedata, i_byteenable));
      end
      if (i_address == din_cond_pkg::OFS_AC_MODE) begin
        nxt_ac = N_INPUTS'(merge_bytes(32'(ac_ff), i_writedata, i_byteenable));
      end
      for (int k = 0; k < N_INPUTS; k++) begin
        if (i_address == din_cond_pkg::OFS_ACT_BASE + 8'(4 * k)) begin
          nxt_act[k] = din_cond_pkg::DELAY_W'(merge_bytes(32'(act_ff[k]), i_writedata, i_byteenable));
        end
        if (i_address == din_cond_pkg::OFS_DROP_BASE + 8'(4 * k)) begin
          nxt_drop[k] = din_cond_pkg::DELAY_W'(merge_bytes(32'(drop_ff[k]), i_writedata, i_byteenable));
        end
      end
    end
    if (i_read & wait_ff) begin
      nxt_rdata = 32'h00000000;
      case (i_address)
        din_cond_pkg::OFS_STATUS: nxt_rdata = 32'(o_status);
        din_cond_pkg::OFS_LOGIC: nxt_rdata = 32'(logic_ff);
        din_cond_pkg::OFS_OUTPUT: nxt_rdata = 32'(out_ff);
        din_cond_pkg::OFS_POLARITY: nxt_rdata = 32'(pol_ff);
        din_cond_pkg::OFS_AC_MODE: nxt_rdata = 32'(ac_ff);
        din_cond_pkg::OFS_SAMPLED: nxt_rdata = 32'(sampled);
        default: begin
          for (int k = 0; k < N_INPUTS; k++) begin
            if (i_address == din_cond_pkg::OFS_ACT_BASE + 8'(4 * k)) begin
              nxt_rdata = 32'(act_ff[k]);
            end
            if (i_address == din_cond_pkg::OFS_DROP_BASE + 8'(4 * k)) begin
              nxt_rdata = 32'(drop_ff[k]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pol_ff <= '0;
      ac_ff <= '0;
      rdata_ff <= 32'h00000000;
      wait_ff <= 1'b1;
      for (int k = 0; k < N_INPUTS; k++) begin
        act_ff[k] <= din_cond_pkg::DELAY_RESET;
        drop_ff[k] <= din_cond_pkg::DELAY_RESET;
      end
    end else begin
      pol_ff <= nxt_pol;
      ac_ff <= nxt_ac;
      rdata_ff <= nxt_rdata;
      wait_ff <= nxt_wait;
      for (int k = 0; k < N_INPUTS; k++) begin
        act_ff[k] <= nxt_act[k];
        drop_ff[k] <= nxt_drop[k];
      end
    end
  end

  assign o_readdata = rdata_ff;
  assign o_waitrequest = wait_ff;

  // Per-input conditioning
  for (genvar g = 0; g < N_INPUTS; g++) begin : g_chan
    input_channel_filter u_chan (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_ms_tick(ms_tick_ff),
      .i_scan_tick(scan_tick_ff),
      .i_raw(i_digital_input_n[g]),
      .i_polarity(pol_ff[g]),
      .i_ac_en(ac_ff[g]),
      .i_act_delay(act_ff[g]),
      .i_drop_delay(drop_ff[g]),
      .o_sampled(sampled[g]),
      .o_status(o_status[g])
    );
  end

  // Logic sees status one scan later, outputs one more round after that
  always_comb begin
    nxt_logic = logic_ff;
    nxt_out = out_ff;
    if (scan_tick_ff) begin
      nxt_logic = o_status;
      nxt_out = logic_ff;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      logic_ff <= '0;
      out_ff <= '0;
    end else begin
      logic_ff <= nxt_logic;
      out_ff <= nxt_out;
    end
  end

  assign o_logic_state = logic_ff;
  assign o_digital_output_n = out_ff;

  a_scan_on_ms: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    scan_tick_ff |-> ms_tick_ff && (scan_cnt_ff == '0) && (ms_cnt_ff == '0))
    else $error("scan tick not aligned to fifth millisecond");
  a_scan_gap: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    ms_tick_ff && !scan_tick_ff |-> scan_cnt_ff != '0)
    else $error("scan counter out of step with ticks");
  a_logic_follow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    scan_tick_ff |=> logic_ff == $past(o_status))
    else $error("logic state did not take status at scan");
  a_logic_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !scan_tick_ff |=> $stable(logic_ff))
    else $error("logic state changed between scans");
  a_output_round: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    scan_tick_ff |=> out_ff == $past(logic_ff))
    else $error("output command skipped its extra round");
  a_output_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !scan_tick_ff |=> $stable(out_ff))
    else $error("output command changed between scans");
  a_bus_answer: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    req && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not given in one cycle");
endmodule : digital_input_conditioner
`default_nettype wire

// File: tb/contact_model.sv
// Purpose: Field contacts energizing the digital inputs
// Assumes: Commanded levels change just after a clock edge
// Notes: No bounce; levels move only on a clock edge
`timescale 1ns/1ps
`default_nettype none
module contact_model #(
  parameter int N = 8
) (
  input wire logic i_clock,
  input wire logic [N-1:0] i_cmd,
  output logic [N-1:0] o_contact
);
  always_ff @(posedge i_clock) begin
    o_contact <= i_cmd;
  end
endmodule : contact_model
`default_nettype wire

// File: tb/test_digital_input_conditioner.sv
// Purpose: Self-checking bench for digital_input_conditioner
// Assumes: MS_CYCLES shortened to 10, so one scan is 50 clocks
// Notes: Timing windows allow for the unknown scan phase
`timescale 1ns/1ps
`default_nettype none
module test_digital_input_conditioner;
  localparam int MS = 10;
  localparam int SCAN = 5 * MS;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] cmd = 8'h00;
  logic [7:0] din;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic waitreq;
  logic [7:0] st;
  logic [7:0] lg;
  logic [7:0] dout;
  int n_mismatch = 0;
  int n_compared = 0;
  always #12.5 i_clock = ~i_clock;
  contact_model #(.N(8)) i_contact (.i_clock(i_clock), .i_cmd(cmd), .o_contact(din));
  digital_input_conditioner #(.N_INPUTS(8), .MS_CYCLES(MS)) i_dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_digital_input_n(din),
    .i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wdat),
    .i_byteenable(4'hF), .o_readdata(rdat), .o_waitrequest(waitreq),
    .o_status(st), .o_logic_state(lg), .o_digital_output_n(dout));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Holds the request until waitrequest is sampled low, then frees the bus for an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    @(posedge i_clock);
    while (waitreq !== 1'b0) begin
      @(posedge i_clock);
      n++;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    check("bus answer", n, 32'h1);
    @(posedge i_clock);
  endtask : bus
  function automatic logic pick(input int sel, input int b);
    return sel == 0 ? st[b] : (sel == 1 ? lg[b] : dout[b]);
  endfunction : pick
  task automatic await(input int sel, input int b, input logic v, input int lim, output int n);
    n = 0;
    while (n < lim && pick(sel, b) !== v) begin
      @(posedge i_clock);
      n++;
    end
  endtask : await
  task automatic t_reset();
    logic [31:0] q;
    bus(1'b0, 8'h0C, 32'h0, q);
    check("polarity reset", q, 32'h0);
    bus(1'b0, 8'h10, 32'h0, q);
    check("ac mode reset", q, 32'h0);
    bus(1'b0, 8'h40, 32'h0, q);
    check("activation reset", q, 32'h0);
    bus(1'b0, 8'h80, 32'h0, q);
    check("drop-off reset", q, 32'h0);
    bus(1'b1, 8'h3C, 32'hFFFFFFFF, q);
    bus(1'b0, 8'h3C, 32'h0, q);
    check("unmapped read", q, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_scan();
    int n;
    logic [31:0] q;
    cmd[0] <= 1'b1;
    await(0, 0, 1'b1, SCAN + 4, n);
    check("status after scan", n <= SCAN + 3, 32'h1);
    await(1, 0, 1'b1, SCAN + 2, n);
    check("logic lag", n >= 1 && n <= SCAN + 1, 32'h1);
    await(2, 0, 1'b1, SCAN + 2, n);
    check("output lag", n >= SCAN - 1 && n <= SCAN + 1, 32'h1);
    bus(1'b0, 8'h00, 32'h0, q);
    check("status register", q, 32'h1);
    bus(1'b0, 8'h04, 32'h0, q);
    check("logic register", q, 32'h1);
    bus(1'b0, 8'h08, 32'h0, q);
    check("output register", q, 32'h1);
    $display("test scan done");
  endtask : t_scan
  task automatic t_polarity();
    int n;
    logic [31:0] q;
    bus(1'b1, 8'h0C, 32'h2, q);
    await(0, 1, 1'b1, SCAN + 4, n);
    check("closed idle status", n <= SCAN + 3, 32'h1);
    bus(1'b0, 8'h14, 32'h0, q);
    check("sampled levels", q & 32'h3, 32'h3);
    cmd[1] <= 1'b1;
    await(0, 1, 1'b0, SCAN + 4, n);
    check("closed energized status", n <= SCAN + 3, 32'h1);
    $display("test polarity done");
  endtask : t_polarity
  task automatic t_activate();
    int n;
    logic [31:0] q;
    bus(1'b1, 8'h48, 32'h3, q);
    cmd[2] <= 1'b1;
    await(0, 2, 1'b1, 12 * MS, n);
    check("activation time", n > 2 * MS && n <= SCAN + 4 * MS + 3, 32'h1);
    $display("test activation done");
  endtask : t_activate
  // A counter that only paused would let the second pulse finish the delay
  task automatic t_cancel();
    int n;
    logic [31:0] q;
    bus(1'b1, 8'h4C, 32'd20, q);
    cmd[3] <= 1'b1;
    repeat (2 * SCAN) @(posedge i_clock);
    cmd[3] <= 1'b0;
    repeat (2 * SCAN) @(posedge i_clock);
    cmd[3] <= 1'b1;
    await(0, 3, 1'b1, 3 * SCAN, n);
    check("short pulses ignored", n, 3 * SCAN);
    await(0, 3, 1'b1, 3 * SCAN, n);
    check("full delay activates", n < 3 * SCAN, 32'h1);
    $display("test cancel done");
  endtask : t_cancel
  task automatic t_drop();
    int n;
    logic [31:0] q;
    bus(1'b1, 8'h90, 32'h2, q);
    bus(1'b1, 8'h10, 32'h10, q);
    cmd[4] <= 1'b1;
    await(0, 4, 1'b1, SCAN + 4, n);
    check("ac input rises", n <= SCAN + 3, 32'h1);
    cmd[4] <= 1'b0;
    await(0, 4, 1'b0, 40 * MS + SCAN, n);
    check("drop-off time", n > 31 * MS && n <= 33 * MS + SCAN + 3, 32'h1);
    $display("test drop-off done");
  endtask : t_drop
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_scan();
    t_polarity();
    t_activate();
    t_cancel();
    t_drop();
    complete_run();
  end
  // The whole sequence needs under 4000 clocks
  initial begin
    repeat (30000) @(posedge i_clock);
    n_mismatch++;
    complete_run();
  end
endmodule : test_digital_input_conditioner
`default_nettype wire
